/* logic/pmx_consts.svh */
// Purpose: Constants of the pad multiplexer and general pin port
// Assumes: 125 MHz mclk, APB register access
// Notes:   Offsets are byte addresses on the APB bus
`ifndef PMX_CONSTS_SVH
`define PMX_CONSTS_SVH

// Pad and signal counts
`define PMX_NPADS        19
`define PMX_NFUNC        34
`define PMX_NROWS        12
`define PMX_NCOLS        11

// Fixed pad positions and pad masks
`define PMX_PAD_DBG_DATA 5
`define PMX_PAD_DBG_CLK  6
`define PMX_PAD_XTAL_IN  13
`define PMX_PAD_XTAL_OUT 14
`define PMX_IRQ_CAPABLE  19'h79fff
`define PMX_ANA_CAPABLE  19'h79c00

// Register offsets
`define PMX_OFS_CTRL     8'h00
`define PMX_OFS_ANA_EN   8'h04
`define PMX_OFS_DIR      8'h08
`define PMX_OFS_DOUT     8'h0c
`define PMX_OFS_DIN      8'h10
`define PMX_OFS_DEB_EN   8'h14
`define PMX_OFS_ISTAT    8'h18
`define PMX_OFS_IMASK    8'h1c
`define PMX_OFS_IPOL     8'h20
`define PMX_OFS_WAKE_EN  8'h24
`define PMX_OFS_FSEL0    8'h40
`define PMX_OFS_FSEL4    8'h50

// Control register fields and reset value
`define PMX_CTRL_DBG     0
`define PMX_CTRL_KSCAN   1
`define PMX_CTRL_XTAL    2
`define PMX_CTRL_RST     3'h5

// Debounce time: least time, rounded up to whole cycles
`define PMX_CLK_NS       8
`define PMX_DEB_TIME_NS  10000
`define PMX_DEB_CYCLES   ((`PMX_DEB_TIME_NS + `PMX_CLK_NS - 1) / `PMX_CLK_NS)

`endif

/* logic/pmx_debounce.sv */
// Purpose: Per-pin input debounce
// Assumes: Inputs already synchronised to mclk
// Notes:   A new level is taken only after it held CNT cycles
`include "pmx_consts.svh"
module pmx_debounce #(
  parameter int unsigned W   = `PMX_NPADS,
  parameter int unsigned CNT = `PMX_DEB_CYCLES
) (
  // Clock and reset
  input  wire logic         mclk,
  input  wire logic         rst_n,
  // Levels
  input  wire logic [W-1:0] raw,
  output logic      [W-1:0] stable
);
  localparam int unsigned CW = $clog2(CNT + 1);
  logic [CW-1:0] cnt_q [W];
  logic [CW-1:0] cnt_d [W];
  logic [W-1:0]  stable_q;
  logic [W-1:0]  stable_d;

  always_comb begin
    stable_d = stable_q;
    for (int i = 0; i < W; i++) begin
      cnt_d[i] = '0;
      if (raw[i] != stable_q[i]) begin
        if (cnt_q[i] == CW'(CNT - 1)) begin
          stable_d[i] = raw[i];
        end else begin
          cnt_d[i] = cnt_q[i] + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      stable_q <= '0;
      for (int i = 0; i < W; i++) begin
        cnt_q[i] <= '0;
      end
    end else begin
      stable_q <= stable_d;
      cnt_q    <= cnt_d;
    end
  end

  assign stable = stable_q;
endmodule

/* logic/pmx_pkg.sv */
// Purpose: Types of the pad multiplexer
// Assumes: Constants come from pmx_consts.svh
// Notes:   Select code 0 leaves a pad with the general pin port
package pmx_pkg;
  typedef enum logic [5:0] {
    PMX_F_GPIO    = 6'h00,
    PMX_F_I2C0_CL = 6'h01, PMX_F_I2C0_DA = 6'h02, PMX_F_I2C1_CL = 6'h03,
    PMX_F_I2C1_DA = 6'h04, PMX_F_I2S_BCK = 6'h05, PMX_F_I2S_WS  = 6'h06,
    PMX_F_I2S_DO  = 6'h07, PMX_F_I2S_DI  = 6'h08, PMX_F_UA0_TX  = 6'h09,
    PMX_F_UA0_RX  = 6'h0a, PMX_F_UA1_TX  = 6'h0b, PMX_F_UA1_RX  = 6'h0c,
    PMX_F_PWM0    = 6'h0d, PMX_F_PWM1    = 6'h0e, PMX_F_PWM2    = 6'h0f,
    PMX_F_PWM3    = 6'h10, PMX_F_PWM4    = 6'h11, PMX_F_PWM5    = 6'h12,
    PMX_F_SP0_CK  = 6'h13, PMX_F_SP0_CS  = 6'h14, PMX_F_SP0_MO  = 6'h15,
    PMX_F_SP0_MI  = 6'h16, PMX_F_SP1_CK  = 6'h17, PMX_F_SP1_CS  = 6'h18,
    PMX_F_SP1_MO  = 6'h19, PMX_F_SP1_MI  = 6'h1a, PMX_F_QD0_A   = 6'h1b,
    PMX_F_QD0_B   = 6'h1c, PMX_F_QD1_A   = 6'h1d, PMX_F_QD1_B   = 6'h1e,
    PMX_F_QD2_A   = 6'h1f, PMX_F_QD2_B   = 6'h20, PMX_F_CLK1P28 = 6'h21,
    PMX_F_DMIC_DO = 6'h22
  } pmx_func_t;
endpackage

/* logic/pmx_top.sv */
// Purpose: Pad signal router and general pin port with APB registers
// Assumes: 125 MHz mclk; pads reach this block as in/out/enable triples
// Notes on behaviour
// R1 - Software routes peripheral signals to any pad
// R2 - Nineteen pads, each peripheral or pin port
// R3 - Routable set has audio, 1.28MHz clock, microphone
// R4 - Enabled fixed functions override routing, fixed pads
// R5 - Key-scan rows and columns follow pad table
// R6 - Default: every pad on pin port, except debug and crystal pads
// R7 - Per-pin direction, readable input, writable output
// R8 - Every pin has debounce; wake-up on all but crystal pads
// R9 - Interrupts on seventeen pins, crystal pads excluded
// R10 - Reset: pin inputs, except debug and crystal
// R11 - Pad 5 debug data out, pad 6 clock
// R12 - Pads 13, 14 crystal analog, no digital use
// R13 - Wake request serves sleep and off states
// R14 - One combined interrupt for line 16
// R15 - Interrupt and wake use debounced level
`include "pmx_consts.svh"
module pmx_top #(
  parameter int unsigned NPADS      = `PMX_NPADS,
  parameter int unsigned NFUNC      = `PMX_NFUNC,
  parameter int unsigned DEB_CYCLES = `PMX_DEB_CYCLES
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             rst_n,
  // APB slave
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [7:0]       paddr,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // Pads
  input  wire logic [NPADS-1:0] pad_in,
  output logic      [NPADS-1:0] pad_out,
  output logic      [NPADS-1:0] pad_oe,
  output logic      [NPADS-1:0] analog_sel,
  output logic                  crystal_in_analog,
  output logic                  crystal_out_analog,
  // Routable peripherals
  input  wire logic [NFUNC-1:0] periph_out,
  input  wire logic [NFUNC-1:0] periph_oe,
  output logic      [NFUNC-1:0] periph_in,
  // Key scan
  input  wire logic [11:0]      keyscan_row_out,
  output logic      [10:0]      keyscan_column_in,
  // Debug port
  input  wire logic             dbg_data_out,
  input  wire logic             dbg_data_oe,
  output logic                  dbg_data_in,
  output logic                  dbg_clk_in,
  // Events
  output logic                  port_irq,
  output logic                  wake_req
);
  localparam logic [NPADS-1:0] IRQ_OK = `PMX_IRQ_CAPABLE;
  localparam logic [NPADS-1:0] ANA_OK = `PMX_ANA_CAPABLE;

  // Pad index to key-scan signal: bit 4 set means column input
  function automatic logic [4:0] ks_map(input int unsigned p);
    case (p)
      0: ks_map = 5'h07;   1: ks_map = 5'h17;   2: ks_map = 5'h06;
      3: ks_map = 5'h18;   4: ks_map = 5'h10;   5: ks_map = 5'h11;
      6: ks_map = 5'h01;   7: ks_map = 5'h1a;   8: ks_map = 5'h04;
      9: ks_map = 5'h14;   10: ks_map = 5'h0b;  11: ks_map = 5'h02;
      12: ks_map = 5'h12;  13: ks_map = 5'h0a;  14: ks_map = 5'h09;
      15: ks_map = 5'h15;  16: ks_map = 5'h05;  17: ks_map = 5'h16;
      18: ks_map = 5'h03;
      default: ks_map = 5'h0f;
    endcase
  endfunction

  function automatic logic is_fsel(input logic [7:0] a);
    is_fsel = (a >= `PMX_OFS_FSEL0) && (a <= `PMX_OFS_FSEL4) && (a[1:0] == 2'b00);
  endfunction

  // Pads are foreign to mclk: two flops before use
  logic [NPADS-1:0] pad_m_q;
  logic [NPADS-1:0] pad_s_q;
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pad_m_q <= '0;
      pad_s_q <= '0;
    end else begin
      pad_m_q <= pad_in;
      pad_s_q <= pad_m_q;
    end
  end

  logic [NPADS-1:0] deb_lvl;
  // R8 debounce per pin
  pmx_debounce #(.W(NPADS), .CNT(DEB_CYCLES)) u_deb (
    .mclk   (mclk),
    .rst_n  (rst_n),
    .raw    (pad_s_q),
    .stable (deb_lvl)
  );

  // Register state
  logic [2:0]             ctrl_q, ctrl_d;
  logic [NPADS-1:0]       ana_q, ana_d, dir_q, dir_d, dout_q, dout_d;
  logic [NPADS-1:0]       deb_q, deb_d, istat_q, istat_d, imask_q, imask_d;
  logic [NPADS-1:0]       ipol_q, ipol_d, wake_q, wake_d;
  pmx_pkg::pmx_func_t     fsel_q [NPADS];
  pmx_pkg::pmx_func_t     fsel_d [NPADS];
  logic [31:0]            prdata_q, prdata_d, rd_word;
  logic                   pready_q, pready_d, pslverr_q, pslverr_d;
  logic [NPADS-1:0]       lvl, lvl_q, irq_set;
  logic                   hit, setup, wr;
  int unsigned            fb;

  // R15 debounced level feeds events
  always_comb begin
    lvl     = (deb_q & deb_lvl) | (~deb_q & pad_s_q);
    // R9 no events on crystal pads
    irq_set = IRQ_OK & ((ipol_q & lvl & ~lvl_q) | (~ipol_q & ~lvl & lvl_q));
  end

  always_comb begin
    setup   = psel && !penable;
    wr      = psel && penable && pready_q && pwrite;
    hit     = 1'b1;
    rd_word = '0;
    fb      = 0;
    case (paddr)
      `PMX_OFS_CTRL:    rd_word[2:0]       = ctrl_q;
      `PMX_OFS_ANA_EN:  rd_word[NPADS-1:0] = ana_q;
      `PMX_OFS_DIR:     rd_word[NPADS-1:0] = dir_q;
      `PMX_OFS_DOUT:    rd_word[NPADS-1:0] = dout_q;
      // R7 input readback
      `PMX_OFS_DIN:     rd_word[NPADS-1:0] = lvl & IRQ_OK;
      `PMX_OFS_DEB_EN:  rd_word[NPADS-1:0] = deb_q;
      `PMX_OFS_ISTAT:   rd_word[NPADS-1:0] = istat_q;
      `PMX_OFS_IMASK:   rd_word[NPADS-1:0] = imask_q;
      `PMX_OFS_IPOL:    rd_word[NPADS-1:0] = ipol_q;
      `PMX_OFS_WAKE_EN: rd_word[NPADS-1:0] = wake_q;
      default: begin
        hit = is_fsel(paddr);
        fb  = 32'(paddr - `PMX_OFS_FSEL0);
        for (int k = 0; k < 4; k++) begin
          if (hit && fb + k < NPADS) begin
            rd_word[8*k +: 6] = fsel_q[fb + k];
          end
        end
      end
    endcase
  end

  always_comb begin
    ctrl_d    = ctrl_q;
    ana_d     = ana_q;
    dir_d     = dir_q;
    dout_d    = dout_q;
    deb_d     = deb_q;
    imask_d   = imask_q;
    ipol_d    = ipol_q;
    wake_d    = wake_q;
    fsel_d    = fsel_q;
    pready_d  = setup;
    pslverr_d = setup && !hit;
    prdata_d  = (setup && !pwrite && hit) ? rd_word : '0;
    // R14 sticky status, set beats clear
    istat_d   = istat_q | irq_set;
    if (wr && hit) begin
      case (paddr)
        `PMX_OFS_CTRL:    ctrl_d  = pwdata[2:0];
        `PMX_OFS_ANA_EN:  ana_d   = pwdata[NPADS-1:0] & ANA_OK;
        // R7 direction and output data
        `PMX_OFS_DIR:     dir_d   = pwdata[NPADS-1:0];
        `PMX_OFS_DOUT:    dout_d  = pwdata[NPADS-1:0];
        `PMX_OFS_DEB_EN:  deb_d   = pwdata[NPADS-1:0];
        `PMX_OFS_ISTAT:   istat_d = (istat_q & ~pwdata[NPADS-1:0]) | irq_set;
        `PMX_OFS_IMASK:   imask_d = pwdata[NPADS-1:0] & IRQ_OK;
        `PMX_OFS_IPOL:    ipol_d  = pwdata[NPADS-1:0];
        `PMX_OFS_WAKE_EN: wake_d  = pwdata[NPADS-1:0] & IRQ_OK;
        default: begin
          // R1 software route select
          for (int k = 0; k < 4; k++) begin
            if (is_fsel(paddr) && fb + k < NPADS) begin
              fsel_d[fb + k] = pmx_pkg::pmx_func_t'(pwdata[8*k +: 6]);
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      // R10 reset to pin inputs
      ctrl_q    <= `PMX_CTRL_RST;
      ana_q     <= '0;
      dir_q     <= '0;
      dout_q    <= '0;
      deb_q     <= '0;
      istat_q   <= '0;
      imask_q   <= '0;
      ipol_q    <= '0;
      wake_q    <= '0;
      lvl_q     <= '0;
      prdata_q  <= '0;
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      // R6 all selects to pin port
      for (int i = 0; i < NPADS; i++) begin
        fsel_q[i] <= pmx_pkg::PMX_F_GPIO;
      end
    end else begin
      ctrl_q    <= ctrl_d;
      ana_q     <= ana_d;
      dir_q     <= dir_d;
      dout_q    <= dout_d;
      deb_q     <= deb_d;
      istat_q   <= istat_d;
      imask_q   <= imask_d;
      ipol_q    <= ipol_d;
      wake_q    <= wake_d;
      lvl_q     <= lvl;
      prdata_q  <= prdata_d;
      pready_q  <= pready_d;
      pslverr_q <= pslverr_d;
      fsel_q    <= fsel_d;
    end
  end

  // Pad steering; priority crystal, debug, key scan, analog, route, port
  logic [NPADS-1:0] pout_d, poe_d, ana_sel_d, pout_q, poe_q, ana_sel_q;
  logic [NFUNC-1:0] pin_d, pin_q;
  logic [10:0]      kcol_d, kcol_q;
  logic             dbg_en, ks_en, xt_en;
  logic [4:0]       km;
  logic [5:0]       fs;
  logic             irq_q, wake_req_q, dbg_di_q, dbg_ck_q;

  always_comb begin
    dbg_en    = ctrl_q[`PMX_CTRL_DBG];
    ks_en     = ctrl_q[`PMX_CTRL_KSCAN];
    xt_en     = ctrl_q[`PMX_CTRL_XTAL];
    pout_d    = dout_q;
    poe_d     = dir_q;
    ana_sel_d = '0;
    pin_d     = '0;
    kcol_d    = '0;
    // R2 every pad own select
    for (int p = 0; p < NPADS; p++) begin
      km = ks_map(p);
      fs = fsel_q[p];
      if (xt_en && (p == `PMX_PAD_XTAL_IN || p == `PMX_PAD_XTAL_OUT)) begin
        // R12 crystal pads analog only
        poe_d[p]     = 1'b0;
        pout_d[p]    = 1'b0;
        ana_sel_d[p] = 1'b1;
      end else if (dbg_en && p == `PMX_PAD_DBG_DATA) begin
        // R11 debug data pad
        pout_d[p] = dbg_data_out;
        poe_d[p]  = dbg_data_oe;
      end else if (dbg_en && p == `PMX_PAD_DBG_CLK) begin
        pout_d[p] = 1'b0;
        poe_d[p]  = 1'b0;
      end else if (ks_en) begin
        // R5 key-scan fixed pads
        if (km[4]) begin
          poe_d[p]  = 1'b0;
          pout_d[p] = 1'b0;
          if (32'(km[3:0]) < `PMX_NCOLS) begin
            kcol_d[km[3:0]] = pad_s_q[p];
          end
        end else begin
          poe_d[p]  = 1'b1;
          pout_d[p] = (32'(km[3:0]) < `PMX_NROWS) ? keyscan_row_out[km[3:0]] : 1'b0;
        end
      end else if (ana_q[p]) begin
        // R4 analog input overrides routing
        poe_d[p]     = 1'b0;
        pout_d[p]    = 1'b0;
        ana_sel_d[p] = 1'b1;
      end else if (fs != 6'h00 && 32'(fs) <= NFUNC) begin
        // R3 any routable signal on any pad
        pout_d[p]    = periph_out[fs - 6'h01];
        poe_d[p]     = periph_oe[fs - 6'h01];
        pin_d[fs - 6'h01] = pad_s_q[p];
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      pout_q     <= '0;
      poe_q      <= '0;
      ana_sel_q  <= '0;
      pin_q      <= '0;
      kcol_q     <= '0;
      irq_q      <= 1'b0;
      wake_req_q <= 1'b0;
      dbg_di_q   <= 1'b0;
      dbg_ck_q   <= 1'b0;
    end else begin
      pout_q     <= pout_d;
      poe_q      <= poe_d;
      ana_sel_q  <= ana_sel_d;
      pin_q      <= pin_d;
      kcol_q     <= kcol_d;
      // R14 one line for the port
      irq_q      <= |(istat_q & imask_q);
      // R13 level wake, registered on mclk, held while the level holds
      wake_req_q <= |(wake_q & IRQ_OK & ~(lvl ^ ipol_q));
      dbg_di_q   <= pad_s_q[`PMX_PAD_DBG_DATA];
      dbg_ck_q   <= pad_s_q[`PMX_PAD_DBG_CLK];
    end
  end

  assign prdata             = prdata_q;
  assign pready             = pready_q;
  assign pslverr            = pslverr_q;
  assign pad_out            = pout_q;
  assign pad_oe             = poe_q;
  assign analog_sel         = ana_sel_q;
  assign crystal_in_analog  = ana_sel_q[`PMX_PAD_XTAL_IN];
  assign crystal_out_analog = ana_sel_q[`PMX_PAD_XTAL_OUT];
  assign periph_in          = pin_q;
  assign keyscan_column_in  = kcol_q;
  assign dbg_data_in        = dbg_di_q;
  assign dbg_clk_in         = dbg_ck_q;
  assign port_irq           = irq_q;
  assign wake_req           = wake_req_q;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  sequence seq_setup;
    psel && !penable;
  endsequence
  sequence seq_done;
    pready_q ##1 !pready_q;
  endsequence

  AST_APB_ANSWER: assert property (seq_setup |=> seq_done) // R7
    else $error("APB answer not one cycle after setup");
  AST_XTAL_QUIET: assert property (xt_en |=> !poe_q[13] && !poe_q[14]) // R12
    else $error("Crystal pad driven");
  AST_XTAL_NOIRQ: assert property (!istat_q[13] && !istat_q[14]) // R9
    else $error("Crystal pad raised status");
  AST_DBG_DATA: assert property (dbg_en |=> pout_q[5] == $past(dbg_data_out)) // R11
    else $error("Debug data not on pad 5");
  AST_KS_PAD4: assert property (ks_en |=> kcol_q[0] == $past(pad_s_q[4])) // R5
    else $error("Key-scan column 0 not from pad 4");
  AST_ROUTE0: assert property (fsel_q[0] == pmx_pkg::PMX_F_I2C0_CL && !ks_en && !ana_q[0]
    |=> pout_q[0] == $past(periph_out[0])) // R1
    else $error("Routed signal missing on pad 0");
  AST_PIN_DIR: assert property (fsel_q[1] == pmx_pkg::PMX_F_GPIO && !ks_en && !ana_q[1]
    |=> poe_q[1] == $past(dir_q[1])) // R7
    else $error("Pin direction not applied");
  AST_STICKY: assert property (irq_set[0] |=> istat_q[0]) // R14
    else $error("Event lost");
  AST_IRQ_OUT: assert property ((istat_q & imask_q) != '0 |=> irq_q) // R14
    else $error("Interrupt not raised");
endmodule

/* sim/pmx_pad_model.sv */
// Purpose: Board side of the nineteen pads
// Assumes: An undriven pad shows the level that the board puts on it
// Notes:   A driven pad reads back its own drive, as a real pad does
module pmx_pad_model #(
  parameter int unsigned N = 19
) (
  // Pad drive from the block
  input  wire logic [N-1:0] pad_out,
  input  wire logic [N-1:0] pad_oe,
  // Board levels
  input  wire logic [N-1:0] board,
  output logic      [N-1:0] pad_in
);
  timeunit 1ns;
  timeprecision 1ps;
  assign pad_in = (pad_oe & pad_out) | (~pad_oe & board);
endmodule

/* sim/tb.sv */
// Purpose: Self-checking bench of the pad router and pin port
// Assumes: Debounce shortened to 4 cycles
// Notes:   Random pads and data from a fixed seed
`include "pmx_consts.svh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int unsigned DEB = 4;
  localparam logic [18:0] M   = `PMX_IRQ_CAPABLE;
  logic        mclk, rst_n, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [18:0] pad_in, pad_out, pad_oe, analog_sel, board, d, v;
  logic [33:0] periph_out, periph_oe, periph_in;
  logic [11:0] keyscan_row_out;
  logic [10:0] keyscan_column_in;
  logic        crystal_in_analog, crystal_out_analog, port_irq, wake_req, er;
  logic        dbg_data_out, dbg_data_oe, dbg_data_in, dbg_clk_in;
  int          bad_count, samples_checked, seed, p, f, k;
  int          rp[10] = '{0, 2, 6, 8, 10, 11, 13, 14, 16, 18};
  int          ri[10] = '{7, 6, 1, 4, 11, 2, 10, 9, 5, 3};
  int          cp[9]  = '{1, 3, 4, 5, 7, 9, 12, 15, 17};
  int          ci[9]  = '{7, 8, 0, 1, 10, 4, 2, 5, 6};

  pmx_top #(.DEB_CYCLES(DEB)) pmx_top_i (
    .mclk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .pad_in, .pad_out, .pad_oe, .analog_sel, .crystal_in_analog,
    .crystal_out_analog, .periph_out, .periph_oe, .periph_in, .keyscan_row_out,
    .keyscan_column_in, .dbg_data_out, .dbg_data_oe, .dbg_data_in, .dbg_clk_in,
    .port_irq, .wake_req
  );
  pmx_pad_model pmx_pad_model_i (.pad_out, .pad_oe, .board, .pad_in);

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  // Expected pin-port level: crystal pads never report
  function automatic logic [18:0] pin_exp(input logic [18:0] b);
    return b & M;
  endfunction

  task automatic chk(input string nm, input logic [33:0] s, input logic [33:0] e);
    samples_checked++;
    if (s !== e) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
    end
  endtask

  // Request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] dat);
    int n;
    n = 0;
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= dat;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) bad_count++;
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge mclk);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    chk(nm, rd, e);
  endtask

  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // Whole run needs about 700 cycles
  initial begin
    repeat (20000) @(posedge mclk);
    bad_count++;
    print_verdict;
  end

  initial begin
    seed = 14;
    {rst_n, psel, penable, pwrite, paddr, pwdata} = '0;
    {board, periph_out, periph_oe, keyscan_row_out} = '0;
    dbg_data_out = 1'b1;
    dbg_data_oe  = 1'b1;
    cyc(8);
    rst_n <= 1'b1;
    cyc(3);
    rdc("ctrl", `PMX_OFS_CTRL, 32'h5);
    rdc("fsel0", `PMX_OFS_FSEL0, 32'h0);
    rdc("dir", `PMX_OFS_DIR, 32'h0);
    chk("oe", pad_oe, 19'h00020);
    chk("out5", pad_out[5], 1'b1);
    chk("ana", analog_sel, 19'h06000);
    chk("xtal", {crystal_in_analog, crystal_out_analog}, 2'b11);
    board[6] <= 1'b1;
    cyc(5);
    chk("dbgclk", dbg_clk_in, 1'b1);
    chk("dbgdata", dbg_data_in, 1'b1);
    apb(1'b0, 8'h3c, 32'h0);
    chk("slverr", {er, rd}, {1'b1, 32'h0});
    // Input register is read-only: a write must leave the selects alone
    apb(1'b1, `PMX_OFS_DIN, 32'h01010101);
    rdc("dinro", `PMX_OFS_FSEL0, 32'h0);
    $display("test reset done");
    // Fixed functions off so every pad is the pin port's
    apb(1'b1, `PMX_OFS_CTRL, 32'h0);
    dbg_data_oe <= 1'b0;
    for (k = 0; k < 4; k++) begin
      d = 19'($random(seed));
      v = 19'($random(seed));
      apb(1'b1, `PMX_OFS_DIR, {13'h0, d});
      apb(1'b1, `PMX_OFS_DOUT, {13'h0, v});
      cyc(2);
      chk("pinoe", pad_oe & M, d & M);
      chk("pinout", pad_out & d & M, v & d & M);
      apb(1'b1, `PMX_OFS_DIR, 32'h0);
      board <= 19'($random(seed));
      cyc(5);
      rdc("din", `PMX_OFS_DIN, {13'h0, pin_exp(board)});
    end
    $display("test pin port done");
    for (f = 1; f <= 34; f++) begin
      p = {$random(seed)} % 17;
      if (p > 12) p += 2;
      if (f == 1) p = 0;
      apb(1'b1, 8'(`PMX_OFS_FSEL0 + 4 * (p / 4)), 32'(f) << (8 * (p % 4)));
      periph_out <= 34'({$random(seed), $random(seed)});
      periph_oe  <= '1;
      cyc(3);
      chk("rout", pad_out[p], periph_out[f-1]);
      chk("roe", pad_oe[p], 1'b1);
      periph_oe <= '0;
      board[p]  <= ~board[p];
      cyc(5);
      chk("rin", periph_in[f-1], board[p]);
      apb(1'b1, 8'(`PMX_OFS_FSEL0 + 4 * (p / 4)), 32'h0);
    end
    $display("test routing done");
    // Pad 0 routed too, so key scan must win it back
    apb(1'b1, `PMX_OFS_CTRL, 32'h2);
    apb(1'b1, `PMX_OFS_FSEL0, 32'h1);
    keyscan_row_out <= 12'($random(seed));
    board           <= 19'($random(seed));
    cyc(5);
    chk("kscanoe", pad_oe[0], 1'b1);
    for (k = 0; k < 10; k++) chk("row", pad_out[rp[k]], keyscan_row_out[ri[k]]);
    for (k = 0; k < 9; k++) chk("col", keyscan_column_in[ci[k]], board[cp[k]]);
    apb(1'b1, `PMX_OFS_FSEL0, 32'h0);
    apb(1'b1, `PMX_OFS_CTRL, 32'h5);
    $display("test key scan done");
    board <= '0;
    cyc(6);
    apb(1'b1, `PMX_OFS_IPOL, 32'h7ffff);
    apb(1'b1, `PMX_OFS_IMASK, 32'h7ffff);
    rdc("imask", `PMX_OFS_IMASK, {13'h0, M});
    apb(1'b1, `PMX_OFS_ISTAT, '1);
    rdc("istat", `PMX_OFS_ISTAT, 32'h0);
    board[0]     <= 1'b1;
    board[14:13] <= 2'b11;
    cyc(6);
    rdc("istat", `PMX_OFS_ISTAT, 32'h1);
    chk("irq", port_irq, 1'b1);
    apb(1'b1, `PMX_OFS_IMASK, 32'h0);
    cyc(1);
    chk("irqmask", port_irq, 1'b0);
    apb(1'b1, `PMX_OFS_IMASK, {13'h0, M});
    apb(1'b1, `PMX_OFS_ISTAT, 32'h1);
    cyc(1);
    rdc("istatclr", `PMX_OFS_ISTAT, 32'h0);
    chk("irqclr", port_irq, 1'b0);
    // Glitch shorter than the debounce span is dropped
    apb(1'b1, `PMX_OFS_DEB_EN, 32'h2);
    board[1] <= 1'b1;
    cyc(DEB - 2);
    board[1] <= 1'b0;
    cyc(10);
    rdc("glitch", `PMX_OFS_ISTAT, 32'h0);
    board[1] <= 1'b1;
    cyc(12);
    rdc("deb", `PMX_OFS_ISTAT, 32'h2);
    rdc("dindeb", `PMX_OFS_DIN, 32'h3);
    $display("test interrupt done");
    apb(1'b1, `PMX_OFS_WAKE_EN, '1);
    rdc("wen", `PMX_OFS_WAKE_EN, {13'h0, M});
    chk("wake", wake_req, 1'b1);
    apb(1'b1, `PMX_OFS_WAKE_EN, 32'h4);
    cyc(1);
    chk("wakeoff", wake_req, 1'b0);
    board[2] <= 1'b1;
    cyc(5);
    chk("wake2", wake_req, 1'b1);
    $display("test wake done");
    // Analog use must beat a pin set to drive
    apb(1'b1, `PMX_OFS_DIR, '1);
    apb(1'b1, `PMX_OFS_ANA_EN, '1);
    rdc("anaen", `PMX_OFS_ANA_EN, {13'h0, `PMX_ANA_CAPABLE});
    chk("anasel", analog_sel, `PMX_ANA_CAPABLE | 19'h06000);
    chk("anaoe", pad_oe & `PMX_ANA_CAPABLE, 19'h0);
    apb(1'b1, `PMX_OFS_ANA_EN, 32'h0);
    cyc(1);
    chk("anaoff", pad_oe & `PMX_ANA_CAPABLE, `PMX_ANA_CAPABLE);
    $display("test analog done");
    print_verdict;
  end
endmodule
